// ==== include/pfr_pkg.sv ====
// package for the shared packed-integer / legacy float stack register file
// assumes a single core clock domain and one instruction issued per cycle
package pfr_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int unsigned NUM_REGS   = 8;
  localparam int unsigned DATA_W     = 64;
  localparam int unsigned IDX_W      = 3;
  localparam int unsigned NUM_PORTS  = 3;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [7:0]  TAG_RESET  = 8'h00;
  localparam logic [2:0]  TOP_RESET  = 3'h0;
  // stall on a packed-to-float switch, in ns, and the cycle count at 10 MHz
  localparam int unsigned SWITCH_NS     = 200;
  localparam int unsigned CLK_NS        = 100;
  localparam int unsigned SWITCH_CYC    = (SWITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  SWITCH_CYC_W  = 4'(SWITCH_CYC);
  // extra cycles for a type-mismatched wide operand
  localparam logic [3:0]  MISMATCH_CYC  = 4'h2;

  // ****************************************
  // operation classes seen by the issue stage
  // ****************************************
  typedef enum logic [2:0] {
    PFR_OP_NONE,
    PFR_OP_PACKED,
    PFR_OP_FLOAT_PUSH,
    PFR_OP_FLOAT_POP,
    PFR_OP_FLOAT_OTHER,
    PFR_OP_EMPTY,
    PFR_OP_WIDE
  } pfr_op_t;

  typedef enum logic {
    PFR_MODE_PACKED,
    PFR_MODE_FLOAT
  } pfr_mode_t;

endpackage

// ==== hw/pfr_regs.sv ====
// shared packed-integer / legacy float stack register storage with tag word
// assumes decode drives op/index/data from logic on clk, one op per cycle
//
// Contract
// - packed and float views share eight registers
// - packed reference sets all tag valid bits
// - empty_packed_state clears all tag valid bits
// - packed-to-float switch stalls issue briefly
// - packed mixes of any width never stall
// - wide and packed mixing never stalls
// - mismatched wide types allowed, extra latency
// - one-per-cycle throughput over three ports
// - wide shuffle/pack/unpack one per cycle too
// - float push on full tags raises overflow
`timescale 1ns/1ps

module pfr_regs #(
  parameter int unsigned NUM_REGS  = pfr_pkg::NUM_REGS,
  parameter int unsigned DATA_W    = pfr_pkg::DATA_W,
  parameter int unsigned NUM_PORTS = pfr_pkg::NUM_PORTS
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       clk_en,
  input  wire logic                       op_valid,
  input  wire pfr_pkg::pfr_op_t           op_kind,
  input  wire logic [pfr_pkg::IDX_W-1:0]  op_idx,
  input  wire logic                       op_wr,
  input  wire logic [DATA_W-1:0]          op_wdata,
  input  wire logic                       op_type_mismatch,
  input  wire logic [NUM_PORTS-1:0]       port_busy,
  output logic                            issue_stall_q,
  output logic [DATA_W-1:0]               rdata_q,
  output logic [NUM_REGS-1:0]             tag_valid_q,
  output logic [pfr_pkg::IDX_W-1:0]       stack_top_q,
  output logic                            stack_overflow_q,
  output logic                            mismatch_busy_q,
  output logic [NUM_PORTS-1:0]            port_grant_q
);

  // ****************************************
  // decode
  // ****************************************
  logic [DATA_W-1:0]         regs_q [NUM_REGS];
  pfr_pkg::pfr_mode_t        mode_q;
  logic [3:0]                stall_cnt_q;
  logic [3:0]                mism_cnt_q;

  wire  logic accept      = clk_en && op_valid && !issue_stall_q && !mismatch_busy_q;
  wire  logic is_packed   = op_kind == pfr_pkg::PFR_OP_PACKED;
  wire  logic is_push     = op_kind == pfr_pkg::PFR_OP_FLOAT_PUSH;
  wire  logic is_pop      = op_kind == pfr_pkg::PFR_OP_FLOAT_POP;
  wire  logic is_float    = is_push || is_pop || op_kind == pfr_pkg::PFR_OP_FLOAT_OTHER;
  wire  logic is_empty    = op_kind == pfr_pkg::PFR_OP_EMPTY;
  wire  logic is_wide     = op_kind == pfr_pkg::PFR_OP_WIDE;
  // only a packed-mode to float switch causes this stall; wide ops never do
  wire  logic switch_hit  = accept && is_float && mode_q == pfr_pkg::PFR_MODE_PACKED;
  // push into a full tag word: the stack has no free slot
  wire  logic ovf_hit     = accept && is_push && (&tag_valid_q);
  wire  logic [pfr_pkg::IDX_W-1:0] push_top = stack_top_q - 3'h1;
  // packed ops address physically, float ops relative to the stack top
  wire  logic [pfr_pkg::IDX_W-1:0] phys_idx =
    is_float ? (is_push ? push_top : stack_top_q + op_idx) : op_idx;
  wire  logic do_write    = accept && op_wr && (is_packed || is_float) && !ovf_hit;
  wire  logic [NUM_PORTS-1:0] port_free = ~port_busy;
  // lowest free port; the borrow stays inside the port width on purpose
  wire  logic [NUM_PORTS-1:0] grant_d   = port_free & ~(port_free - NUM_PORTS'(1));

  // ****************************************
  // storage: one array serves both views
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      localparam int unsigned SLOT = g;
      // each entry written from whichever view addresses it
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          regs_q[g] <= '0;
        end else if (do_write && phys_idx == SLOT[pfr_pkg::IDX_W-1:0]) begin
          regs_q[g] <= op_wdata;
        end
      end
    end
  endgenerate

  // read data, tag word and stack top
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q     <= '0;
      tag_valid_q <= pfr_pkg::TAG_RESET;
      stack_top_q <= pfr_pkg::TOP_RESET;
    end else if (accept) begin
      rdata_q <= regs_q[phys_idx];
      if (is_packed) begin
        tag_valid_q <= '1;
        stack_top_q <= pfr_pkg::TOP_RESET;
      end else if (is_empty) begin
        tag_valid_q <= '0;
      end else if (is_push && !ovf_hit) begin
        tag_valid_q[push_top] <= 1'b1;
        stack_top_q           <= push_top;
      end else if (is_pop) begin
        tag_valid_q[stack_top_q] <= 1'b0;
        stack_top_q              <= stack_top_q + 3'h1;
      end
    end
  end

  // mode tracking and the switch stall; packed after packed never stalls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q        <= pfr_pkg::PFR_MODE_FLOAT;
      stall_cnt_q   <= '0;
      issue_stall_q <= 1'b0;
    end else if (clk_en) begin
      if (accept && is_packed) begin
        mode_q <= pfr_pkg::PFR_MODE_PACKED;
      end else if (accept && (is_float || is_empty)) begin
        mode_q <= pfr_pkg::PFR_MODE_FLOAT;
      end
      if (switch_hit) begin
        stall_cnt_q   <= pfr_pkg::SWITCH_CYC_W;
        issue_stall_q <= 1'b1;
      end else if (stall_cnt_q != 4'h0) begin
        stall_cnt_q   <= stall_cnt_q - 4'h1;
        issue_stall_q <= stall_cnt_q != 4'h1;
      end
    end
  end

  // overflow flag is a one-cycle event pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_overflow_q <= 1'b0;
    end else if (clk_en) begin
      stack_overflow_q <= ovf_hit;
    end
  end

  // mismatched wide operands: result unchanged, extra latency only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mism_cnt_q      <= '0;
      mismatch_busy_q <= 1'b0;
    end else if (clk_en) begin
      if (accept && is_wide && op_type_mismatch) begin
        mism_cnt_q      <= pfr_pkg::MISMATCH_CYC;
        mismatch_busy_q <= 1'b1;
      end else if (mism_cnt_q != 4'h0) begin
        mism_cnt_q      <= mism_cnt_q - 4'h1;
        mismatch_busy_q <= mism_cnt_q != 4'h1;
      end
    end
  end

  // port steering: lowest free port each cycle, so every packed or wide op
  // including shuffle/pack/unpack issues once per cycle while a port is free
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_grant_q <= '0;
    end else if (clk_en) begin
      port_grant_q <= (accept && (is_packed || is_wide)) ? grant_d : '0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // tag word follows packed and empty-state ops one cycle later
  a_packed_sets_tags: assert property (
    @(posedge clk) disable iff (!rst_n)
    accept && is_packed |=> tag_valid_q == '1)
    else $error("tags not set");
  a_empty_clears_tags: assert property (
    @(posedge clk) disable iff (!rst_n)
    accept && is_empty |=> tag_valid_q == '0)
    else $error("tags not cleared");

  // stall length is only pinned while the enable stays high, since a
  // frozen cycle legally stretches it
  a_switch_stall_len: assert property (
    @(posedge clk) disable iff (!rst_n)
    switch_hit ##1 clk_en [*2] |-> issue_stall_q && $past(issue_stall_q) ##1 !issue_stall_q)
    else $error("switch stall length wrong");
  a_stall_refuses: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && op_valid && (issue_stall_q || mismatch_busy_q)
      |=> $stable(tag_valid_q) && $stable(stack_top_q) && $stable(rdata_q))
    else $error("refused op changed state");
  a_packed_no_stall: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && accept && is_packed && !mismatch_busy_q |=> !issue_stall_q)
    else $error("packed op stalled");
  a_stall_needs_switch: assert property (
    @(posedge clk) disable iff (!rst_n)
    !switch_hit && !issue_stall_q |=> !issue_stall_q)
    else $error("stall without a switch");
  a_wide_no_stall: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && accept && is_wide && !op_type_mismatch |=> !issue_stall_q && !mismatch_busy_q)
    else $error("wide op stalled");

  // mismatched operands only cost time, and only the chosen amount
  a_mismatch_latency: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && accept && is_wide && op_type_mismatch |=> mismatch_busy_q)
    else $error("mismatch latency missing");
  a_mismatch_len: assert property (
    @(posedge clk) disable iff (!rst_n)
    accept && is_wide && op_type_mismatch ##1 clk_en [*2]
      |-> mismatch_busy_q && $past(mismatch_busy_q) ##1 !mismatch_busy_q)
    else $error("mismatch latency length wrong");

  // overflow leaves the stack untouched and never fires on a free slot
  a_overflow_pulse: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && accept && is_push && tag_valid_q == '1
      |=> stack_overflow_q && $stable(tag_valid_q) && $stable(stack_top_q))
    else $error("overflow not raised");
  a_overflow_needs_full: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && !ovf_hit |=> !stack_overflow_q)
    else $error("overflow without full stack");
  a_one_grant: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && accept && (is_packed || is_wide) && port_busy != '1
      |=> $onehot(port_grant_q) && (port_grant_q & $past(port_busy)) == '0)
    else $error("port grant wrong");

  // both views land in the same storage
  a_shared_view: assert property (
    @(posedge clk) disable iff (!rst_n)
    accept && is_packed && op_wr |=> regs_q[$past(op_idx)] == $past(op_wdata))
    else $error("write not stored");
  a_float_view: assert property (
    @(posedge clk) disable iff (!rst_n)
    accept && is_push && op_wr && !(&tag_valid_q) |=> regs_q[stack_top_q] == $past(op_wdata))
    else $error("push not stored");

  // a low enable must freeze every visible piece of state
  a_frozen_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    !clk_en |=> $stable(tag_valid_q) && $stable(stack_top_q) && $stable(rdata_q)
      && $stable(issue_stall_q) && $stable(mismatch_busy_q))
    else $error("state moved while frozen");

endmodule // pfr_regs

// ==== testbench/pfr_unit_model.sv ====
// execution-unit busy model facing the issue stage of the shared register file
// assumes the bench picks which units are occupied; one clock domain
`timescale 1ns/1ps
module pfr_unit_model (
  input  wire logic [2:0] busy_set,
  output logic [2:0]      port_busy
);
  // level busy flags; the bench never marks all three busy, so one is always free
  assign port_busy = busy_set;
endmodule // pfr_unit_model

// ==== testbench/packed_int_fp_shared_regs_tb_top.sv ====
// self-checking bench for the shared packed-integer / float stack registers
// assumes pfr_pkg and pfr_regs compiled first; 10 MHz clock
`timescale 1ns/1ps
module packed_int_fp_shared_regs_tb_top;
  typedef struct packed {
    logic [7:0] tag; logic [63:0] rd; logic chk; logic ovf; logic [2:0] gnt; logic [2:0] top;
  } pfr_note_t;
  logic clk = 0, rst_n = 0, op_valid = 0, op_wr = 0, mm = 0, ce = 1'b1;
  pfr_pkg::pfr_op_t op_kind = pfr_pkg::PFR_OP_NONE;
  logic [2:0] op_idx = 0, busy_set = 0, port_busy, stack_top_q, port_grant_q;
  logic [63:0] op_wdata = 0, rdata_q;
  logic [7:0] tag_valid_q, tg = 0;
  logic issue_stall_q, stack_overflow_q, mismatch_busy_q, acc = 0;
  logic [63:0] rf [8] = '{default: 64'h0};
  logic [2:0] top = 0;
  pfr_note_t notes[$];
  int n_fail = 0, n_checks = 0, cyc = 0;
  pfr_regs dut_u (.clk(clk), .rst_n(rst_n), .clk_en(ce), .op_valid(op_valid),
    .op_kind(op_kind), .op_idx(op_idx), .op_wr(op_wr), .op_wdata(op_wdata),
    .op_type_mismatch(mm), .port_busy(port_busy), .issue_stall_q(issue_stall_q),
    .rdata_q(rdata_q), .tag_valid_q(tag_valid_q), .stack_top_q(stack_top_q),
    .stack_overflow_q(stack_overflow_q), .mismatch_busy_q(mismatch_busy_q),
    .port_grant_q(port_grant_q));
  pfr_unit_model unit_u (.busy_set(busy_set), .port_busy(port_busy));
  always #50 clk = ~clk;
  // ****************************************
  // close and hang guard
  // ****************************************
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin n_fail++; close_out(); end
  end
  // ****************************************
  // monitor: one result a cycle after each accepted op
  // ****************************************
  always @(posedge clk) acc <= rst_n & ce & op_valid & !issue_stall_q & !mismatch_busy_q;
  always @(negedge clk) if (acc) begin
    pfr_note_t n;
    n_checks++;
    if (notes.size() == 0) begin n_fail++; $display("[FAIL] %0t extra result", $time); end
    else begin
      n = notes.pop_front();
      if (tag_valid_q !== n.tag || stack_overflow_q !== n.ovf || port_grant_q !== n.gnt
          || stack_top_q !== n.top
          || (n.chk && rdata_q !== n.rd)) begin
        n_fail++; $display("[FAIL] %0t result differs", $time);
      end
    end
  end
  // ****************************************
  // driver: offer one op, note its result, count refused cycles
  // ****************************************
  task automatic issue(input pfr_pkg::pfr_op_t k, input logic [2:0] i, input int ew,
                       input logic m = 1'b0);
    pfr_note_t n; int w; logic [2:0] b; logic [2:0] s; logic [63:0] d;
    b = 3'($urandom % 7);
    d = {$urandom, $urandom};
    op_valid <= 1'b1; op_kind <= k; op_idx <= i; op_wr <= 1'b1; op_wdata <= d;
    mm <= m; busy_set <= b;
    n = '{tag: 8'h0, rd: 64'h0, chk: 1'b0, ovf: 1'b0, gnt: 3'h0, top: 3'h0};
    case (k)
      pfr_pkg::PFR_OP_PACKED: begin n.rd = rf[i]; n.chk = 1; rf[i] = d; tg = 8'hFF; top = 0; end
      pfr_pkg::PFR_OP_EMPTY: tg = 8'h00;
      pfr_pkg::PFR_OP_FLOAT_PUSH: if (tg == 8'hFF) n.ovf = 1'b1;
        else begin top = top - 3'h1; rf[top] = d; tg[top] = 1'b1; end
      pfr_pkg::PFR_OP_FLOAT_OTHER, pfr_pkg::PFR_OP_FLOAT_POP: begin
        s = top + i; n.rd = rf[s]; n.chk = 1; rf[s] = d;
        if (k == pfr_pkg::PFR_OP_FLOAT_POP) begin tg[top] = 1'b0; top = top + 3'h1; end
      end
      default: ;
    endcase
    if (k == pfr_pkg::PFR_OP_PACKED || k == pfr_pkg::PFR_OP_WIDE) n.gnt = ~b & (b + 3'h1);
    n.tag = tg;
    n.top = top;
    w = 0;
    @(negedge clk);
    while (issue_stall_q || mismatch_busy_q) begin w++; @(negedge clk); end
    notes.push_back(n);
    @(posedge clk);
    n_checks++;
    if (w != ew) begin
      n_fail++; $display("[FAIL] %0t refused %0d cycles", $time, w);
    end
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hCA4A));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    n_checks++;
    if (tag_valid_q !== pfr_pkg::TAG_RESET || stack_top_q !== pfr_pkg::TOP_RESET) begin
      n_fail++; $display("[FAIL] %0t reset state", $time);
    end
    $display("reset state done");
    for (int r = 0; r < 8; r++) issue(pfr_pkg::PFR_OP_PACKED, 3'(r), 0);
    issue(pfr_pkg::PFR_OP_WIDE, 3'h0, 0);
    for (int r = 0; r < 8; r++) issue(pfr_pkg::PFR_OP_PACKED, 3'(r), 0);
    $display("packed fill and readback done");
    issue(pfr_pkg::PFR_OP_FLOAT_PUSH, 3'h0, 0);
    issue(pfr_pkg::PFR_OP_NONE, 3'h0, 2);
    issue(pfr_pkg::PFR_OP_NONE, 3'h0, 0);
    $display("overflow and switch stall done");
    issue(pfr_pkg::PFR_OP_EMPTY, 3'h0, 0);
    issue(pfr_pkg::PFR_OP_FLOAT_PUSH, 3'h0, 0);
    issue(pfr_pkg::PFR_OP_FLOAT_PUSH, 3'h0, 0);
    issue(pfr_pkg::PFR_OP_FLOAT_OTHER, 3'h1, 0);
    issue(pfr_pkg::PFR_OP_FLOAT_POP, 3'h0, 0);
    issue(pfr_pkg::PFR_OP_PACKED, 3'h7, 0);
    issue(pfr_pkg::PFR_OP_PACKED, 3'h6, 0);
    issue(pfr_pkg::PFR_OP_EMPTY, 3'h0, 0);
    $display("shared view done");
    issue(pfr_pkg::PFR_OP_WIDE, 3'h0, 0, 1'b1);
    issue(pfr_pkg::PFR_OP_NONE, 3'h0, 2);
    issue(pfr_pkg::PFR_OP_WIDE, 3'h0, 0, 1'b1);
    // enable low as the mismatch latency starts: the busy count and the tags must not move
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    n_checks++;
    if (mismatch_busy_q !== 1'b1 || tag_valid_q !== tg) begin
      n_fail++; $display("[FAIL] %0t freeze", $time);
    end
    @(posedge clk);
    ce <= 1'b1;
    $display("clock enable freeze done");
    issue(pfr_pkg::PFR_OP_NONE, 3'h0, 2);
    for (int r = 0; r < 12; r++)
      issue($urandom % 2 ? pfr_pkg::PFR_OP_WIDE : pfr_pkg::PFR_OP_PACKED, 3'($urandom), 0);
    $display("wide mix done");
    op_valid <= 1'b0;
    repeat (3) @(posedge clk);
    close_out();
  end
endmodule // packed_int_fp_shared_regs_tb_top
